// *** logic/ctc_core.sv ***
/*
  Compressor transient control: look-ahead clip guard, crest-factor fast
  release, gain smoothing with hysteresis and start-up gain.
  Assumes the static curve supplies target_gain on the same clock, and
  a plain register port whose read data is due one cycle after the strobe.
*/
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module ctc_core #(
  parameter int DCY_CYC = ctc_pkg::DCY_BASE_CYC,
  parameter int FR0_CYC = ctc_pkg::FR0_CYC,
  parameter int FR1_CYC = ctc_pkg::FR1_CYC,
  parameter int FR2_CYC = ctc_pkg::FR2_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire ctc_pkg::ctc_smp_t in_s,
  input wire ctc_pkg::ctc_gain_t target_gain,
  input wire logic start,
  output ctc_pkg::ctc_smp_t out_s,
  output ctc_pkg::ctc_gain_t gain_o
);

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} ctc_state_t;

  logic rs1_q, rs2_q, rst_s_n;
  logic [15:0] ctrl0_q, ctrl1_q;
  logic [15:0] avg_q, peak_q, mag, peak_dec;
  logic crest_q, clip_q, moving_q;
  ctc_state_t st_q;
  ctc_pkg::ctc_gain_t gain_q, tgt, lo_lim, hi_lim, ig_half;
  logic signed [8:0] diff;
  logic [8:0] adiff;
  logic [2:0] hthr;
  logic [31:0] cnt_q, per;
  logic [23:0] crest_ref;
  logic signed [15:0] dly;
  logic clip_en, fr_en, sm_en, hy_en;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mag16(input logic signed [15:0] x);
    logic [16:0] n;
    n = 17'h00000 - {x[15], x};
    if (!x[15])
      mag16 = x;
    else if (n[16])
      mag16 = 16'h7FFF;
    else
      mag16 = n[15:0];
  endfunction

  function automatic logic [31:0] ms_cyc(input logic [1:0] c);
    unique case (c)
      2'b00: ms_cyc = 32'(FR0_CYC);
      2'b01: ms_cyc = 32'(FR1_CYC);
      default: ms_cyc = 32'(FR2_CYC);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end
    else
    begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_s_n = rs2_q;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      ctrl0_q <= ctc_pkg::CTRL0_RST;
      ctrl1_q <= ctc_pkg::CTRL1_RST;
    end
    else if (wr && addr == ctc_pkg::ADDR_CTRL0)
      ctrl0_q <= wdata;
    else if (wr && addr == ctc_pkg::ADDR_CTRL1)
      ctrl1_q <= wdata;
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      rdata <= 16'h0000;
    else if (rd)
    begin
      unique case (addr)
        ctc_pkg::ADDR_CTRL0: rdata <= ctrl0_q;
        ctc_pkg::ADDR_CTRL1: rdata <= ctrl1_q;
        ctc_pkg::ADDR_STAT:
          rdata <= {gain_q, 5'h00, moving_q, crest_q, clip_q};
        default: rdata <= 16'h0000;
      endcase
    end
  end

  assign clip_en = ctrl0_q[ctc_pkg::CLIP_EN_BIT];
  assign fr_en = ctrl0_q[ctc_pkg::FR_EN_BIT];
  assign sm_en = ctrl0_q[ctc_pkg::SM_EN_BIT];
  assign hy_en = ctrl0_q[ctc_pkg::HYST_EN_BIT];

  // ----------------------------------------------------------------
  // Level detection
  // ----------------------------------------------------------------
  assign mag = mag16(in_s.data);
  assign peak_dec = peak_q - (peak_q >> ctc_pkg::PEAK_SHIFT);
  // Threshold is 2^(code+2): 12 dB ~ x4 up to 30 dB ~ x32
  assign crest_ref = {8'h00, avg_q} <<
    (ctc_pkg::CREST_BASE + 32'(ctrl1_q[ctc_pkg::THR_LSB +: 2]));

  // Leaky average of magnitude stands in for RMS; cheap, no multiplier
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      avg_q <= 16'h0000;
      peak_q <= 16'h0000;
    end
    else if (in_s.valid)
    begin
      avg_q <= avg_q - (avg_q >> ctc_pkg::AVG_SHIFT)
             + (mag >> ctc_pkg::AVG_SHIFT);
      peak_q <= (mag > peak_dec) ? mag : peak_dec;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      crest_q <= 1'b0;
    else if (!fr_en)
      crest_q <= 1'b0;
    else
      crest_q <= {8'h00, peak_q} > crest_ref;
  end

  // Undelayed sample well above the average flags a rising edge
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      clip_q <= 1'b0;
    else if (!clip_en)
      clip_q <= 1'b0;
    else if (in_s.valid)
      clip_q <= mag > (avg_q << ctc_pkg::CLIP_SHIFT);
  end

  // ----------------------------------------------------------------
  // Look-ahead path
  // ----------------------------------------------------------------
  ctc_delay u_delay (
    .clk(clk),
    .rst_n(rst_s_n),
    .long_sel(ctrl0_q[ctc_pkg::LA_SEL_BIT]),
    .in_s(in_s),
    .out_d(dly)
  );

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      out_s <= '0;
    else
    begin
      out_s.valid <= in_s.valid;
      out_s.data <= clip_en ? dly : in_s.data;
    end
  end

  // ----------------------------------------------------------------
  // Gain target, limits and hysteresis
  // ----------------------------------------------------------------
  assign lo_lim = 8'(-12 * int'(ctrl1_q[ctc_pkg::MIN_LSB +: 2]));
  assign hi_lim = ctrl1_q[ctc_pkg::MAX_LSB +: 2] == 2'b11 ? 8'h48
                : 8'(24 + 12 * int'(ctrl1_q[ctc_pkg::MAX_LSB +: 2]));
  assign tgt = (target_gain < lo_lim) ? lo_lim
             : (target_gain > hi_lim) ? hi_lim : target_gain;
  assign diff = 9'(tgt) - 9'(gain_q);
  assign adiff = diff[8] ? 9'(-diff) : 9'(diff);
  assign ig_half = 8'(ctrl0_q[ctc_pkg::IG_LSB +: 5]) - 8'(ctc_pkg::IG_ZERO);

  always_comb
  begin
    hthr = 3'h1;
    if (hy_en)
    begin
      unique case (ctrl0_q[ctc_pkg::HL_LSB +: 2])
        2'b00: hthr = ctc_pkg::HYST_LOW;
        2'b01: hthr = ctc_pkg::HYST_MED;
        default: hthr = ctc_pkg::HYST_HIGH;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Step period
  // ----------------------------------------------------------------
  always_comb
  begin
    if (diff[8])
    begin
      // Reserved attack code 0 runs as the fastest rate
      per = 32'(ctc_pkg::ATK_BASE_CYC) <<
            (ctrl1_q[ctc_pkg::ATK_LSB +: 4] == 4'h0 ? 4'h0
             : ctrl1_q[ctc_pkg::ATK_LSB +: 4] - 4'h1);
      if (clip_q)
        per = per >> 2;
    end
    else if (crest_q)
      per = ms_cyc(ctrl1_q[ctc_pkg::FRR_LSB +: 2]);
    else
      per = 32'(DCY_CYC) << ctrl1_q[ctc_pkg::DCY_LSB +: 4];
    if (per == 32'h0)
      per = 32'h1;
  end

  // ----------------------------------------------------------------
  // Gain ramp
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      st_q <= ST_IDLE;
      gain_q <= 8'h00;
      cnt_q <= 32'h0;
      moving_q <= 1'b0;
    end
    else if (start)
    begin
      st_q <= ST_RUN;
      gain_q <= ig_half;
      cnt_q <= 32'h0;
      moving_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
          gain_q <= ig_half;
        ST_RUN:
        begin
          // Hold until the error reaches the threshold, then ramp home
          if (adiff == 9'h0)
            moving_q <= 1'b0;
          else if (adiff >= 9'(hthr))
            moving_q <= 1'b1;
          if (!moving_q || adiff == 9'h0)
            cnt_q <= 32'h0;
          else if (cnt_q >= per - 32'h1)
          begin
            cnt_q <= 32'h0;
            gain_q <= diff[8] ? gain_q - 8'h01 : gain_q + 8'h01;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Smoothing filter
  // ----------------------------------------------------------------
  logic signed [8:0] sdiff;
  assign sdiff = 9'(gain_q) - 9'(gain_o);

  // Shift alone would stall short of the target; force a unit step
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      gain_o <= 8'h00;
    else if (!sm_en)
      gain_o <= gain_q;
    else if (in_s.valid && sdiff != 9'h0)
    begin
      if ((sdiff >>> ctc_pkg::SM_SHIFT) == 9'h0)
        gain_o <= gain_o + 8'h01;
      else if ((sdiff >>> ctc_pkg::SM_SHIFT) == 9'h1FF)
        gain_o <= gain_o - 8'h01;
      else
        gain_o <= gain_o + 8'(sdiff >>> ctc_pkg::SM_SHIFT);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_bypass;
    @(posedge clk) disable iff (!rst_s_n)
    !clip_en && in_s.valid |=> out_s.valid && out_s.data == $past(in_s.data);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("delay not bypassed with clip guard off");

  property p_crest_off;
    @(posedge clk) disable iff (!rst_s_n)
    !fr_en |=> !crest_q;
  endproperty
  a_crest_off: assert property (p_crest_off)
    else $error("crest flag set with fast release off");

  property p_step_time;
    @(posedge clk) disable iff (!rst_s_n)
    st_q == ST_RUN && !$past(start) && gain_q != $past(gain_q) |->
      $past(cnt_q) == $past(per) - 32'h1;
  endproperty
  a_step_time: assert property (p_step_time)
    else $error("gain stepped before its period elapsed");

  property p_init;
    @(posedge clk) disable iff (!rst_s_n)
    start |=> gain_q == $past(ig_half) && st_q == ST_RUN;
  endproperty
  a_init: assert property (p_init)
    else $error("start-up gain not loaded");

  property p_hold;
    @(posedge clk) disable iff (!rst_s_n)
    st_q == ST_RUN && !moving_q && !start |=> gain_q == $past(gain_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("gain moved inside hysteresis band");

  property p_sm_off;
    @(posedge clk) disable iff (!rst_s_n)
    !sm_en |=> gain_o == $past(gain_q);
  endproperty
  a_sm_off: assert property (p_sm_off)
    else $error("smoothing not bypassed");

  property p_one_step;
    @(posedge clk) disable iff (!rst_s_n)
    st_q == ST_RUN && !$past(start) |->
      gain_q - $past(gain_q) inside {8'h00, 8'h01, 8'hFF};
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("gain moved more than one step");

  property p_clip_fast;
    @(posedge clk) disable iff (!rst_s_n)
    clip_q && diff[8] |-> per <= (32'(ctc_pkg::ATK_BASE_CYC) << 9) >> 2;
  endproperty
  a_clip_fast: assert property (p_clip_fast)
    else $error("attack not sped up on clip guard");

endmodule

// *** logic/ctc_delay.sv ***
/*
  Sample delay line for the look-ahead path, 5 or 9 samples deep.
  Assumes samples arrive on one clock with a valid qualifier.
*/
`timescale 1ns/1ps
module ctc_delay (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic long_sel,
  input wire ctc_pkg::ctc_smp_t in_s,
  output logic signed [15:0] out_d
);

  logic signed [15:0] mem_q [ctc_pkg::LA_LONG];

  // ----------------------------------------------------------------
  // Shift register, advancing once per sample
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < ctc_pkg::LA_LONG; i++)
        mem_q[i] <= 16'h0000;
    end
    else if (in_s.valid)
    begin
      mem_q[0] <= in_s.data;
      for (int i = 1; i < ctc_pkg::LA_LONG; i++)
        mem_q[i] <= mem_q[i-1];
    end
  end

  // Tap k-1 holds the sample taken k samples ago
  assign out_d = long_sel ? mem_q[ctc_pkg::LA_LONG-1]
                          : mem_q[ctc_pkg::LA_SHORT-1];

  property p_long_tap;
    @(posedge clk) disable iff (!rst_n)
    long_sel && in_s.valid ##1 long_sel |->
      out_d == $past(mem_q[ctc_pkg::LA_LONG-2]);
  endproperty
  a_long_tap: assert property (p_long_tap)
    else $error("long look-ahead tap not nine samples deep");

endmodule

// *** logic/ctc_pkg.sv ***
/*
  Constants, field positions and carrier types for the compressor
  transient control block. Assumes a 50 MHz core clock and 16-bit samples.
*/
package ctc_pkg;

  // ----------------------------------------------------------------
  // Clock and bus
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] ADDR_CTRL0 = 8'h28;
  localparam logic [7:0] ADDR_CTRL1 = 8'h29;
  localparam logic [7:0] ADDR_STAT = 8'h2A;
  localparam logic [15:0] CTRL0_RST = 16'h01AF;
  localparam logic [15:0] CTRL1_RST = 16'h3248;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HYST_EN_BIT = 0;
  localparam int CLIP_EN_BIT = 1;
  localparam int FR_EN_BIT = 2;
  localparam int SM_EN_BIT = 3;
  localparam int LA_SEL_BIT = 5;
  localparam int IG_LSB = 6;
  localparam int HL_LSB = 11;
  localparam int ATK_LSB = 12;
  localparam int DCY_LSB = 8;
  localparam int THR_LSB = 6;
  localparam int FRR_LSB = 4;
  localparam int MIN_LSB = 2;
  localparam int MAX_LSB = 0;

  // ----------------------------------------------------------------
  // Look-ahead and level detection
  // ----------------------------------------------------------------
  localparam int LA_SHORT = 5;
  localparam int LA_LONG = 9;
  localparam int AVG_SHIFT = 6;
  localparam int PEAK_SHIFT = 8;
  localparam int CLIP_SHIFT = 1;
  localparam int CREST_BASE = 2;
  localparam int SM_SHIFT = 2;

  // ----------------------------------------------------------------
  // Gain, in half-dB units
  // ----------------------------------------------------------------
  localparam logic [4:0] IG_ZERO = 5'h06;
  localparam logic [4:0] IG_MAX = 5'h12;
  localparam logic [2:0] HYST_LOW = 3'h1;
  localparam logic [2:0] HYST_MED = 3'h2;
  localparam logic [2:0] HYST_HIGH = 3'h4;

  // ----------------------------------------------------------------
  // Ramp timing: one gain step is 1/12 of 6 dB
  // ----------------------------------------------------------------
  localparam int STEPS_6DB = 12;
  localparam int ATK_BASE_NS = 182_000;
  localparam int DCY_BASE_NS = 186_000_000;
  localparam int FR0_NS = 725_000;
  localparam int FR1_NS = 1_450_000;
  localparam int FR2_NS = 5_800_000;
  localparam int ATK_BASE_CYC = ATK_BASE_NS / (STEPS_6DB * CLK_NS);
  localparam int DCY_BASE_CYC = DCY_BASE_NS / (STEPS_6DB * CLK_NS);
  localparam int FR0_CYC = FR0_NS / (STEPS_6DB * CLK_NS);
  localparam int FR1_CYC = FR1_NS / (STEPS_6DB * CLK_NS);
  localparam int FR2_CYC = FR2_NS / (STEPS_6DB * CLK_NS);

  typedef logic signed [7:0] ctc_gain_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] data;
  } ctc_smp_t;

endpackage

// *** verif/ctc_path.sv ***
/*
  Sample source standing in for the codec's audio sample path.
  Assumes the bench raises go for each sample wanted, after a clock edge.
*/
`timescale 1ns/1ps
module ctc_path (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [15:0] mask,
  input wire logic [15:0] bias,
  output ctc_pkg::ctc_smp_t in_s
);
  logic [15:0] lfsr_q;

  // ----------------------------------------------------------------
  // Sample generation
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr_q <= 16'hACE1;
      in_s <= '0;
    end
    else
    begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                 ^ lfsr_q[10]};
      in_s.valid <= go;
      // Data is only meaningful with valid; invert it otherwise
      in_s.data <= go ? signed'((lfsr_q & mask) | bias) : ~in_s.data;
    end
  end
endmodule

// *** verif/tb.sv ***
/*
  Self-checking bench for the compressor transient control block.
  Assumes the sample source model and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic start = 1'b0;
  logic go = 1'b0;
  logic [15:0] mask = 16'hFFFF;
  logic [15:0] bias = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] d;
  logic chk_on = 1'b0;
  int dly = 0;
  int errors = 0;
  int comparisons = 0;
  logic signed [15:0] hist[$];
  ctc_pkg::ctc_gain_t target_gain = 8'h00;
  ctc_pkg::ctc_gain_t gain_o;
  ctc_pkg::ctc_gain_t g0;
  ctc_pkg::ctc_smp_t in_s;
  ctc_pkg::ctc_smp_t out_s;

  always #10 clk = ~clk;

  ctc_path src (.clk(clk), .rst_n(rst_n), .go(go), .mask(mask),
    .bias(bias), .in_s(in_s));

  ctc_core #(.DCY_CYC(4), .FR0_CYC(2), .FR1_CYC(3), .FR2_CYC(5)) dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .in_s(in_s), .target_gain(target_gain),
    .start(start), .out_s(out_s), .gain_o(gain_o));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [15:0] c0(input logic [1:0] hl,
    input logic [4:0] ig, input logic la, sm, fr, clip, hy);
    return {3'h0, hl, ig, la, 1'b0, sm, fr, clip, hy};
  endfunction

  function automatic logic [15:0] c1(input logic [3:0] atk, dcy,
    input logic [1:0] thr, frr);
    return {atk, dcy, thr, frr, 4'h8};
  endfunction

  function automatic ctc_pkg::ctc_gain_t sm_step(
    input ctc_pkg::ctc_gain_t g, t);
    ctc_pkg::ctc_gain_t s;
    s = (t - g) >>> 2;
    if (s == 0)
      s = (t > g) ? 8'sh01 : -8'sh01;
    return g + s;
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic pulse_start();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask

  task automatic send(input int n);
    repeat (n)
    begin
      // One sample per loop: go stands for exactly one edge
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat ($urandom_range(0, 2)) @(posedge clk);
    end
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic wait_g(input ctc_pkg::ctc_gain_t g, input int lim);
    int n;
    n = 0;
    while (gain_o !== g && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Sample history, newest first, compared against the output stream
  always @(posedge clk)
  begin
    if (chk_on && out_s.valid === 1'b1 && hist.size() > 9)
      check(out_s.data, hist[dly]);
    if (in_s.valid === 1'b1)
      hist.push_front(in_s.data);
    if (hist.size() > 16)
      void'(hist.pop_back());
  end

  initial
  begin
    #2_000_000;
    errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] v;
    int h;
    void'($urandom(32'h244883f4));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(ctc_pkg::ADDR_CTRL0, d);
    check(d, 16'h01AF);
    rd_reg(ctc_pkg::ADDR_CTRL1, d);
    check(d, 16'h3248);
    wr_reg(8'h30, 16'hFFFF);
    rd_reg(8'h30, d);
    check(d, 16'h0000);
    // Random legal settings, no reserved codes written
    repeat (8)
    begin
      v = c0($urandom_range(0, 2), $urandom_range(0, 18), $urandom,
        $urandom, $urandom, $urandom, $urandom);
      wr_reg(ctc_pkg::ADDR_CTRL0, v);
      rd_reg(ctc_pkg::ADDR_CTRL0, d);
      check(d & 16'h1FEF, v);
      v = c1($urandom_range(1, 10), $urandom_range(0, 8),
        $urandom, $urandom_range(0, 2));
      wr_reg(ctc_pkg::ADDR_CTRL1, v);
      rd_reg(ctc_pkg::ADDR_CTRL1, d);
      check(d, v);
    end
    // Look-ahead depth and bypass
    for (int m = 0; m < 3; m++)
    begin
      wr_reg(ctc_pkg::ADDR_CTRL0, c0(2'h1, 5'h06, m == 0, 1, 1, m < 2, 1));
      send(12);
      dly = (m == 0) ? 9 : (m == 1) ? 5 : 0;
      chk_on = 1'b1;
      send(20);
      chk_on = 1'b0;
    end
    // Start-up gain, smoothing off, every legal code
    for (int c = 0; c <= 18; c++)
    begin
      wr_reg(ctc_pkg::ADDR_CTRL0, c0(2'h0, c[4:0], 1, 0, 0, 0, 1));
      target_gain <= 8'(c - 6);
      pulse_start();
      repeat (3) @(posedge clk);
      #1;
      check({8'h00, gain_o}, {8'h00, 8'(c - 6)});
    end
    // Hysteresis levels, then hysteresis off with high level
    wr_reg(ctc_pkg::ADDR_CTRL1, c1(4'h1, 4'h0, 2'h1, 2'h0));
    for (int l = 0; l < 4; l++)
    begin
      h = (l == 3) ? 2 : (l == 2) ? 4 : l + 1;
      wr_reg(ctc_pkg::ADDR_CTRL0,
        c0((l == 3) ? 2'h2 : 2'(l), 5'h06, 1, 0, 0, 0, l != 3));
      target_gain <= 8'h00;
      pulse_start();
      target_gain <= 8'(h - 1);
      repeat (100) @(posedge clk);
      #1;
      // With hysteresis off even a one-step error must move the gain
      check({8'h00, gain_o}, (l == 3) ? 16'h0001 : 16'h0000);
      target_gain <= 8'(h);
      wait_g(8'(h), 200);
      check({8'h00, gain_o}, {8'h00, 8'(h)});
    end
    // Attack lowers gain at one step per 758 cycles
    target_gain <= -8'sh01;
    repeat (600) @(posedge clk);
    #1;
    check({8'h00, gain_o}, 16'h0002);
    wait_g(-8'sh01, 3000);
    check({8'h00, gain_o}, 16'h00FF);
    // Fast release after a transient spike, each rate, then disabled
    for (int r = 0; r < 4; r++)
    begin
      wr_reg(ctc_pkg::ADDR_CTRL1, c1(4'h1, 4'h8, 2'h0, 2'(r % 3)));
      wr_reg(ctc_pkg::ADDR_CTRL0, c0(2'h0, 5'h06, 1, 0, r < 3, 0, 0));
      target_gain <= 8'h00;
      pulse_start();
      mask <= 16'h0000;
      bias <= 16'h0000;
      // Long silence pulls the average down so the spike has a high crest
      send(128);
      bias <= 16'h7000;
      send(1);
      target_gain <= 8'h04;
      rd_reg(ctc_pkg::ADDR_STAT, d);
      check({15'h0, d[1]}, {15'h0, r < 3});
      repeat (100) @(posedge clk);
      #1;
      check({8'h00, gain_o}, (r < 3) ? 16'h0004 : 16'h0000);
    end
    bias <= 16'h0000;
    mask <= 16'hFFFF;
    // Smoothing moves the output gain only on samples
    wr_reg(ctc_pkg::ADDR_CTRL0, c0(2'h0, 5'h12, 1, 1, 0, 0, 0));
    target_gain <= 8'h0C;
    g0 = gain_o;
    pulse_start();
    repeat (10) @(posedge clk);
    #1;
    check({8'h00, gain_o}, {8'h00, g0});
    send(1);
    repeat (3) @(posedge clk);
    #1;
    check({8'h00, gain_o}, {8'h00, sm_step(g0, 8'h0C)});
    send(20);
    check({8'h00, gain_o}, 16'h000C);
    // Clip guard quarters the attack period after a sudden rise
    wr_reg(ctc_pkg::ADDR_CTRL0, c0(2'h0, 5'h12, 1, 0, 0, 1, 0));
    mask <= 16'h0000;
    send(32);
    bias <= 16'h7000;
    send(1);
    target_gain <= 8'h0A;
    rd_reg(ctc_pkg::ADDR_STAT, d);
    check({15'h0, d[0]}, 16'h0001);
    repeat (500) @(posedge clk);
    #1;
    check({8'h00, gain_o}, 16'h000A);
    wrap_up();
  end
endmodule
